/* File: core/fcx_consts.vh */
`ifndef FCX_CONSTS_VH
`define FCX_CONSTS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define FCX_ADDR_W          8
`define FCX_OFS_HARD_STAT   8'h00
`define FCX_OFS_MM_STAT     8'h04
`define FCX_OFS_BUS_STAT    8'h08
`define FCX_OFS_USAGE_STAT  8'h0C
`define FCX_OFS_MM_ADDR     8'h10
`define FCX_OFS_BUS_ADDR    8'h14
`define FCX_OFS_PRI_CFG     8'h18
`define FCX_OFS_HND_EN      8'h1C
`define FCX_OFS_LOCK_STAT   8'h20

// ----------------------------------------------------------------
// status field positions
// ----------------------------------------------------------------
`define FCX_HF_VECTOR       1
`define FCX_HF_ESCALATE     30
`define FCX_MM_INSTR        0
`define FCX_MM_DATA         1
`define FCX_MM_POP          3
`define FCX_MM_PUSH         4
`define FCX_MM_ADDR_VALID   7
`define FCX_BF_IFETCH       0
`define FCX_BF_EXACT        1
`define FCX_BF_INEXACT      2
`define FCX_BF_POP          3
`define FCX_BF_PUSH         4
`define FCX_BF_ADDR_VALID   7
`define FCX_UF_UNKNOWN_OP   0
`define FCX_UF_BAD_STATE    1
`define FCX_UF_BAD_RETURN   2
`define FCX_UF_NO_COPROC    3
`define FCX_UF_MISALIGN     8
`define FCX_UF_ZERO_DIV     9

// priority config: one field per configurable class, 8 bits apart
`define FCX_PRI_MM_LSB      0
`define FCX_PRI_BUS_LSB     8
`define FCX_PRI_USAGE_LSB   16
`define FCX_PRI_RESET       3'h0
`define FCX_HND_EN_RESET    3'h0

// ----------------------------------------------------------------
// handler classes on exec_class and fault_take_class
// ----------------------------------------------------------------
`define FCX_CLS_NONE        3'h0
`define FCX_CLS_HARD        3'h1
`define FCX_CLS_MM          3'h2
`define FCX_CLS_BUS         3'h3
`define FCX_CLS_USAGE       3'h4
`define FCX_CLS_NMI         3'h5
`define FCX_CLS_OTHER       3'h6

// ----------------------------------------------------------------
// valid exception return values
// ----------------------------------------------------------------
`define FCX_RET_HANDLER_MAIN 32'hFFFFFFF1
`define FCX_RET_THREAD_MAIN  32'hFFFFFFF9
`define FCX_RET_THREAD_PROC  32'hFFFFFFFD

`endif

/* File: core/fcx_escalate.v */
`timescale 1ns/1ns
// ----------------------------------------------------------------
// escalation test for one configurable fault class
// ----------------------------------------------------------------
module fcx_escalate #(
   parameter PRI_W = 3
) (
   input  wire             raise,
   input  wire             handler_en,
   input  wire             in_handler,
   input  wire [PRI_W-1:0] exec_pri,
   input  wire [PRI_W-1:0] class_pri,
   input  wire             exempt,
   output wire             escalate
);
   // lower number is higher priority; equal cannot preempt either
   wire cannot_preempt;
   assign cannot_preempt = in_handler & (class_pri >= exec_pri);
   // disabled handler goes to hard fault unless the event is exempt
   assign escalate = raise & ~exempt & (~handler_en | cannot_preempt);
endmodule // fcx_escalate

/* File: core/fcx_fault_unit.v */
// Implementation choices: the register offsets and the strobed register port.
`timescale 1ns/1ns
`include "fcx_consts.vh"

module fcx_fault_unit #(
   parameter PRI_W = 3
) (
   input  wire                   clk_sys,
   input  wire                   rst,
   // register port
   input  wire [`FCX_ADDR_W-1:0] reg_addr,
   input  wire [31:0]            reg_wdata,
   input  wire                   reg_wr,
   input  wire                   reg_rd,
   output reg  [31:0]            reg_rdata,
   // fault reports, one-cycle pulses
   input  wire                   ev_vector_bus_err,
   input  wire                   ev_fetch_mismatch,
   input  wire                   ev_fetch_never_execute,
   input  wire                   ev_data_mismatch,
   input  wire                   ev_push_mismatch,
   input  wire                   ev_pop_mismatch,
   input  wire                   ev_push_bus_err,
   input  wire                   ev_pop_bus_err,
   input  wire                   ev_prefetch_bus_err,
   input  wire                   ev_exact_bus_err,
   input  wire                   ev_inexact_bus_err,
   input  wire                   ev_coproc,
   input  wire                   ev_unknown_opcode,
   input  wire                   ev_bad_state,
   input  wire                   ev_misalign,
   input  wire                   ev_zero_div,
   input  wire                   ev_return_load,
   input  wire [31:0]            exception_return_value,
   input  wire [31:0]            fault_access_addr,
   // execution context
   input  wire                   in_handler,
   input  wire [2:0]             exec_class,
   input  wire [PRI_W-1:0]       exec_pri,
   input  wire                   entering_bus_handler,
   input  wire                   nmi_req,
   input  wire                   debug_halt,
   // results
   output reg                    fault_take,
   output reg  [2:0]             fault_take_class,
   output reg                    lockup
);

   // ----------------------------------------------------------------
   // registers
   // ----------------------------------------------------------------
   reg  [31:0]      hard_fault_status_q;
   reg  [7:0]       memmanage_fault_status_q;
   reg  [7:0]       bus_fault_status_q;
   reg  [9:0]       usage_fault_status_q;
   reg  [31:0]      memmanage_fault_addr_q;
   reg  [31:0]      bus_fault_addr_q;
   reg  [3*PRI_W-1:0] fault_priority_config_q;
   reg  [2:0]       fault_handler_enables_q;
   reg              lock_from_nmi_q;

   // ----------------------------------------------------------------
   // event decode
   // ----------------------------------------------------------------
   // never-execute counts whether or not the protection unit is on
   wire mm_instr_ev;
   wire ret_valid;
   wire bad_return_ev;
   wire [2:0] raise;
   assign mm_instr_ev   = ev_fetch_mismatch | ev_fetch_never_execute;
   // only the three all-ones return patterns are legal
   assign ret_valid     = (exception_return_value == `FCX_RET_HANDLER_MAIN) |
                          (exception_return_value == `FCX_RET_THREAD_MAIN) |
                          (exception_return_value == `FCX_RET_THREAD_PROC);
   assign bad_return_ev = ev_return_load & ~ret_valid;
   assign raise[0] = mm_instr_ev | ev_data_mismatch | ev_push_mismatch | ev_pop_mismatch;
   assign raise[1] = ev_push_bus_err | ev_pop_bus_err | ev_prefetch_bus_err |
                     ev_exact_bus_err | ev_inexact_bus_err;
   assign raise[2] = ev_coproc | ev_unknown_opcode | ev_bad_state | ev_misalign |
                     ev_zero_div | bad_return_ev;

   // ----------------------------------------------------------------
   // escalation per configurable class
   // ----------------------------------------------------------------
   // a push failure on the way into the bus handler is still serviced there
   wire [2:0] exempt;
   wire [2:0] escalate;
   assign exempt = {1'b0, ev_push_bus_err & entering_bus_handler, 1'b0};

   genvar gi;
   generate
      for (gi = 0; gi < 3; gi = gi + 1) begin : g_cls
         fcx_escalate #(
            .PRI_W      (PRI_W)
         ) u_esc (
            .raise      (raise[gi]),
            .handler_en (fault_handler_enables_q[gi]),
            .in_handler (in_handler),
            .exec_pri   (exec_pri),
            .class_pri  (fault_priority_config_q[gi*PRI_W +: PRI_W]),
            .exempt     (exempt[gi]),
            .escalate   (escalate[gi])
         );
      end
   endgenerate

   // a handler cannot preempt itself, whatever its priority field holds
   wire [2:0] self_class;
   wire [2:0] esc_any;
   assign self_class = {(exec_class == `FCX_CLS_USAGE),
                        (exec_class == `FCX_CLS_BUS),
                        (exec_class == `FCX_CLS_MM)};
   assign esc_any    = escalate | (raise & ~exempt & self_class);

   // ----------------------------------------------------------------
   // handler selection
   // ----------------------------------------------------------------
   // one fault is taken per cycle: mm first, then bus, then usage
   reg  [2:0] sel_class;
   reg        sel_escalate;
   reg        hard_req;
   reg        in_top_handler;
   always @* begin
      sel_class    = `FCX_CLS_NONE;
      sel_escalate = 1'b0;
      if (raise[0]) begin
         sel_class    = `FCX_CLS_MM;
         sel_escalate = esc_any[0];
      end else if (raise[1]) begin
         sel_class    = `FCX_CLS_BUS;
         sel_escalate = esc_any[1];
      end else if (raise[2]) begin
         sel_class    = `FCX_CLS_USAGE;
         sel_escalate = esc_any[2];
      end
      // an escalated fault still leaves its own cause flag behind
      hard_req       = ev_vector_bus_err | sel_escalate;
      in_top_handler = (exec_class == `FCX_CLS_HARD) | (exec_class == `FCX_CLS_NMI);
   end

   // ----------------------------------------------------------------
   // take and lockup
   // ----------------------------------------------------------------
   // hard fault preempts anything except nmi and itself; there it locks
   wire lock_enter;
   wire nmi_release;
   wire lock_leave;
   assign lock_enter  = hard_req & in_top_handler;
   // an nmi cannot end a lockup that the nmi handler itself caused
   assign nmi_release = nmi_req & ~lock_from_nmi_q;
   assign lock_leave  = debug_halt | nmi_release;

   always @(posedge clk_sys) begin
      if (rst) begin
         fault_take       <= 1'b0;
         fault_take_class <= `FCX_CLS_NONE;
         lockup           <= 1'b0;
         lock_from_nmi_q  <= 1'b0;
      end else begin
         fault_take       <= 1'b0;
         fault_take_class <= `FCX_CLS_NONE;
         if (lock_enter) begin
            lockup <= 1'b1;
            // a further hard fault while locked keeps the first origin
            if (!lockup) begin
               lock_from_nmi_q <= (exec_class == `FCX_CLS_NMI);
            end
         end else if (lockup) begin
            // no instruction runs in lockup, so nothing is taken
            if (lock_leave) begin
               lockup          <= 1'b0;
               lock_from_nmi_q <= 1'b0;
            end
         end else if (hard_req) begin
            // hard fault outranks every configurable class
            fault_take       <= 1'b1;
            fault_take_class <= `FCX_CLS_HARD;
         end else if (sel_class != `FCX_CLS_NONE) begin
            fault_take       <= 1'b1;
            fault_take_class <= sel_class;
         end
      end
   end

   // ----------------------------------------------------------------
   // cause flags, write one to clear, a new event beats the clear
   // ----------------------------------------------------------------
   reg  [31:0] hard_set;
   reg  [7:0]  mm_set;
   reg  [7:0]  bus_set;
   reg  [9:0]  usage_set;
   // several causes in one cycle all record, even when only one is taken
   always @* begin
      hard_set  = 32'h00000000;
      mm_set    = 8'h00;
      bus_set   = 8'h00;
      usage_set = 10'h000;
      hard_set[`FCX_HF_VECTOR]     = ev_vector_bus_err;
      hard_set[`FCX_HF_ESCALATE]   = sel_escalate;
      mm_set[`FCX_MM_INSTR]        = mm_instr_ev;
      mm_set[`FCX_MM_DATA]         = ev_data_mismatch;
      mm_set[`FCX_MM_PUSH]         = ev_push_mismatch;
      mm_set[`FCX_MM_POP]          = ev_pop_mismatch;
      mm_set[`FCX_MM_ADDR_VALID]   = ev_data_mismatch;
      bus_set[`FCX_BF_PUSH]        = ev_push_bus_err;
      bus_set[`FCX_BF_POP]         = ev_pop_bus_err;
      bus_set[`FCX_BF_IFETCH]      = ev_prefetch_bus_err;
      bus_set[`FCX_BF_EXACT]       = ev_exact_bus_err;
      bus_set[`FCX_BF_INEXACT]     = ev_inexact_bus_err;
      bus_set[`FCX_BF_ADDR_VALID]  = ev_exact_bus_err;
      usage_set[`FCX_UF_NO_COPROC] = ev_coproc;
      usage_set[`FCX_UF_UNKNOWN_OP] = ev_unknown_opcode;
      usage_set[`FCX_UF_BAD_STATE] = ev_bad_state;
      usage_set[`FCX_UF_BAD_RETURN] = bad_return_ev;
      usage_set[`FCX_UF_MISALIGN]  = ev_misalign;
      usage_set[`FCX_UF_ZERO_DIV]  = ev_zero_div;
   end

   // clear masks from a write to the matching status offset
   wire [31:0] wr_clr;
   wire        clr_hard;
   wire        clr_mm;
   wire        clr_bus;
   wire        clr_usage;
   assign wr_clr    = reg_wdata;
   assign clr_hard  = reg_wr & (reg_addr == `FCX_OFS_HARD_STAT);
   assign clr_mm    = reg_wr & (reg_addr == `FCX_OFS_MM_STAT);
   assign clr_bus   = reg_wr & (reg_addr == `FCX_OFS_BUS_STAT);
   assign clr_usage = reg_wr & (reg_addr == `FCX_OFS_USAGE_STAT);

   always @(posedge clk_sys) begin
      if (rst) begin
         hard_fault_status_q      <= 32'h00000000;
         memmanage_fault_status_q <= 8'h00;
         bus_fault_status_q       <= 8'h00;
         usage_fault_status_q     <= 10'h000;
      end else begin
         hard_fault_status_q      <= (hard_fault_status_q &
                                      ~(clr_hard ? wr_clr : 32'h00000000)) | hard_set;
         memmanage_fault_status_q <= (memmanage_fault_status_q &
                                      ~(clr_mm ? wr_clr[7:0] : 8'h00)) | mm_set;
         bus_fault_status_q       <= (bus_fault_status_q &
                                      ~(clr_bus ? wr_clr[7:0] : 8'h00)) | bus_set;
         usage_fault_status_q     <= (usage_fault_status_q &
                                      ~(clr_usage ? wr_clr[9:0] : 10'h000)) | usage_set;
      end
   end

   // ----------------------------------------------------------------
   // fault address capture
   // ----------------------------------------------------------------
   // only the exact data faults know the address that was accessed
   // a later fault overwrites the address; handlers read it on entry
   always @(posedge clk_sys) begin
      if (rst) begin
         memmanage_fault_addr_q <= 32'h00000000;
         bus_fault_addr_q       <= 32'h00000000;
      end else begin
         if (ev_data_mismatch) begin
            memmanage_fault_addr_q <= fault_access_addr;
         end
         if (ev_exact_bus_err) begin
            bus_fault_addr_q <= fault_access_addr;
         end
      end
   end

   // ----------------------------------------------------------------
   // configuration registers
   // ----------------------------------------------------------------
   // priorities and enables are the only plain read-write fields
   always @(posedge clk_sys) begin
      if (rst) begin
         fault_priority_config_q <= {3{`FCX_PRI_RESET}};
         fault_handler_enables_q <= `FCX_HND_EN_RESET;
      end else if (reg_wr) begin
         if (reg_addr == `FCX_OFS_PRI_CFG) begin
            fault_priority_config_q <= {reg_wdata[`FCX_PRI_USAGE_LSB +: PRI_W],
                                        reg_wdata[`FCX_PRI_BUS_LSB +: PRI_W],
                                        reg_wdata[`FCX_PRI_MM_LSB +: PRI_W]};
         end
         if (reg_addr == `FCX_OFS_HND_EN) begin
            fault_handler_enables_q <= reg_wdata[2:0];
         end
      end
   end

   // ----------------------------------------------------------------
   // read data, one cycle after the strobe, zero elsewhere
   // ----------------------------------------------------------------
   reg [31:0] rd_mux;
   always @* begin
      rd_mux = 32'h00000000;
      case (reg_addr)
         `FCX_OFS_HARD_STAT:  rd_mux = hard_fault_status_q;
         `FCX_OFS_MM_STAT:    rd_mux = {24'h000000, memmanage_fault_status_q};
         `FCX_OFS_BUS_STAT:   rd_mux = {24'h000000, bus_fault_status_q};
         `FCX_OFS_USAGE_STAT: rd_mux = {22'h000000, usage_fault_status_q};
         `FCX_OFS_MM_ADDR:    rd_mux = memmanage_fault_addr_q;
         `FCX_OFS_BUS_ADDR:   rd_mux = bus_fault_addr_q;
         `FCX_OFS_PRI_CFG: begin
            rd_mux[`FCX_PRI_MM_LSB +: PRI_W]    = fault_priority_config_q[0 +: PRI_W];
            rd_mux[`FCX_PRI_BUS_LSB +: PRI_W]   = fault_priority_config_q[PRI_W +: PRI_W];
            rd_mux[`FCX_PRI_USAGE_LSB +: PRI_W] = fault_priority_config_q[2*PRI_W +: PRI_W];
         end
         `FCX_OFS_HND_EN:     rd_mux = {29'h00000000, fault_handler_enables_q};
         `FCX_OFS_LOCK_STAT:  rd_mux = {30'h00000000, lock_from_nmi_q, lockup};
         default:             rd_mux = 32'h00000000;
      endcase
   end

   // data is zero outside the answer cycle
   always @(posedge clk_sys) begin
      if (rst) begin
         reg_rdata <= 32'h00000000;
      end else begin
         reg_rdata <= reg_rd ? rd_mux : 32'h00000000;
      end
   end

endmodule // fcx_fault_unit

/* File: dv/fcx_src_model.sv */
`timescale 1ns/1ns
// ----------------------------------------------------------------
// fault reporter: pipeline, protection checker and bus in one
// ----------------------------------------------------------------
module fcx_src_model (
   input  wire        clk_sys,
   input  wire        rst,
   input  wire        fire,
   input  wire [4:0]  sel,
   input  wire [31:0] addr,
   output reg  [16:0] ev_q,
   output reg  [31:0] addr_q
);
   // one-cycle report; address only valid beside its pulse
   always @(posedge clk_sys) begin
      if (rst) begin
         ev_q   <= 17'h0;
         addr_q <= 32'h0;
      end else if (fire) begin
         ev_q   <= 17'h1 << sel;
         addr_q <= addr;
      end else begin
         ev_q   <= 17'h0;
         addr_q <= ~addr_q; // stale address flips every idle cycle, back to the reported one every second cycle
      end
   end
endmodule // fcx_src_model

/* File: dv/fcx_fault_unit_chk.sv */
`timescale 1ns/1ns
`include "fcx_consts.vh"
// ----------------------------------------------------------------
// port checker for the fault unit
// ----------------------------------------------------------------
module fcx_fault_unit_chk #(
   parameter PRI_W = 3
) (
   input  wire                   clk_sys,
   input  wire                   rst,
   input  wire [`FCX_ADDR_W-1:0] reg_addr,
   input  wire [31:0]            reg_wdata,
   input  wire                   reg_wr,
   input  wire ev_vector_bus_err, ev_fetch_mismatch, ev_fetch_never_execute, ev_data_mismatch,
   input  wire ev_push_mismatch, ev_pop_mismatch, ev_push_bus_err, ev_pop_bus_err,
   input  wire ev_prefetch_bus_err, ev_exact_bus_err, ev_inexact_bus_err, ev_coproc,
   input  wire ev_unknown_opcode, ev_bad_state, ev_misalign, ev_zero_div, ev_return_load,
   input  wire in_handler, entering_bus_handler, nmi_req, debug_halt, fault_take, lockup,
   input  wire [2:0]             exec_class,
   input  wire [2:0]             fault_take_class,
   input  wire [PRI_W-1:0]       exec_pri
);
   wire [16:0] ev_all = {ev_vector_bus_err, ev_fetch_mismatch, ev_fetch_never_execute, ev_data_mismatch,
      ev_push_mismatch, ev_pop_mismatch, ev_push_bus_err, ev_pop_bus_err, ev_prefetch_bus_err,
      ev_exact_bus_err, ev_inexact_bus_err, ev_coproc, ev_unknown_opcode, ev_bad_state,
      ev_misalign, ev_zero_div, ev_return_load};
   // the take checks below (not the lockup checks) apply only outside lockup and outside hard/nmi handlers
   wire ok_ctx = !lockup && exec_class != `FCX_CLS_HARD && exec_class != `FCX_CLS_NMI;
   reg [2:0]       en_q;
   reg [PRI_W-1:0] upri_q;
   reg             nmi_lock_q;
   // shadow of software settings; nmi origin frozen while locked
   always @(posedge clk_sys) begin
      if (rst) begin
         en_q       <= 3'h0;
         upri_q     <= {PRI_W{1'b0}};
         nmi_lock_q <= 1'b0;
      end else begin
         if (reg_wr && reg_addr == `FCX_OFS_HND_EN) en_q <= reg_wdata[2:0];
         if (reg_wr && reg_addr == `FCX_OFS_PRI_CFG) upri_q <= reg_wdata[`FCX_PRI_USAGE_LSB +: PRI_W];
         if (!lockup) nmi_lock_q <= (exec_class == `FCX_CLS_NMI);
      end
   end
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (rst);
   sequence s_take_of(logic [2:0] c);
      fault_take && fault_take_class == c;
   endsequence
   a_vector_hard: assert property (ev_vector_bus_err && ok_ctx |=> s_take_of(`FCX_CLS_HARD))
      else $error("vector read error did not take hard fault");
   a_disabled_esc: assert property (ev_zero_div && !en_q[2] && ok_ctx |=> s_take_of(`FCX_CLS_HARD))
      else $error("fault with disabled handler not escalated");
   a_usage_taken: assert property (ev_unknown_opcode && en_q[2] && !in_handler && ok_ctx && $onehot(ev_all)
      |=> s_take_of(`FCX_CLS_USAGE))
      else $error("enabled usage fault not taken as usage");
   a_low_pri_esc: assert property (ev_misalign && en_q[2] && in_handler && upri_q >= exec_pri && ok_ctx
      |=> s_take_of(`FCX_CLS_HARD))
      else $error("same or lower priority fault not escalated");
   a_self_esc: assert property (ev_zero_div && exec_class == `FCX_CLS_USAGE && ok_ctx && $onehot(ev_all)
      |=> s_take_of(`FCX_CLS_HARD))
      else $error("fault inside its own handler not escalated");
   a_push_no_esc: assert property (ev_push_bus_err && entering_bus_handler && ok_ctx && $onehot(ev_all)
      |=> s_take_of(`FCX_CLS_BUS))
      else $error("push error into bus handler escalated");
   a_lock_enter: assert property (ev_vector_bus_err && !lockup &&
      (exec_class == `FCX_CLS_HARD || exec_class == `FCX_CLS_NMI) |=> lockup && !fault_take)
      else $error("hard fault in hard or nmi handler did not lock up");
   a_lock_no_take: assert property (lockup |=> !fault_take)
      else $error("handler taken while locked");
   a_lock_hold: assert property (lockup && !debug_halt && !nmi_req |=> lockup)
      else $error("lockup left without cause");
   a_nmi_kept: assert property (lockup && nmi_lock_q && nmi_req && !debug_halt |=> lockup)
      else $error("nmi released lockup entered from nmi");
   a_lock_leave: assert property (lockup && debug_halt && ev_all == 17'h0 |=> !lockup)
      else $error("debug halt did not release lockup");
endmodule // fcx_fault_unit_chk

bind fcx_fault_unit fcx_fault_unit_chk #(.PRI_W(PRI_W)) u_chk (.*);

/* File: dv/tb_top.sv */
`timescale 1ns/1ns
// ----------------------------------------------------------------
// directed bench: every cause, escalation, lockup, reset
// ----------------------------------------------------------------
module tb_top;
   logic clk_sys = 0, rst = 1, reg_wr = 0, reg_rd = 0, fire = 0, in_handler = 0;
   logic entering_bus_handler = 0, nmi_req = 0, debug_halt = 0;
   logic [7:0]  reg_addr = 8'h00;
   logic [31:0] reg_wdata = 32'h0, src_addr = 32'h0, rd_v;
   logic [4:0]  sel = 5'h00;
   logic [2:0]  exec_class = 3'h0, exec_pri = 3'h0;
   wire  [16:0] ev;
   wire  [31:0] acc_addr, reg_rdata;
   wire         fault_take, lockup;
   wire  [2:0]  fault_take_class;
   int bad_count = 0, checked = 0;
   logic [31:0] expf [4] = '{32'h0, 32'h0, 32'h0, 32'h0};
   // per cause, in model order: status register index, flag bit, handler class
   localparam int RIX [17] = '{0, 1, 1, 1, 1, 1, 2, 2, 2, 2, 2, 3, 3, 3, 3, 3, 3};
   localparam int BITN [17] = '{1, 0, 0, 1, 4, 3, 4, 3, 0, 1, 2, 3, 0, 1, 8, 9, 2};
   localparam int CLS [17] = '{1, 2, 2, 2, 2, 2, 3, 3, 3, 3, 3, 4, 4, 4, 4, 4, 4};

   fcx_src_model src (.clk_sys(clk_sys), .rst(rst), .fire(fire), .sel(sel), .addr(src_addr),
      .ev_q(ev), .addr_q(acc_addr));
   fcx_fault_unit #(.PRI_W(3)) uut (.clk_sys(clk_sys), .rst(rst), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
      .ev_vector_bus_err(ev[0]), .ev_fetch_mismatch(ev[1]), .ev_fetch_never_execute(ev[2]),
      .ev_data_mismatch(ev[3]), .ev_push_mismatch(ev[4]), .ev_pop_mismatch(ev[5]),
      .ev_push_bus_err(ev[6]), .ev_pop_bus_err(ev[7]), .ev_prefetch_bus_err(ev[8]),
      .ev_exact_bus_err(ev[9]), .ev_inexact_bus_err(ev[10]), .ev_coproc(ev[11]),
      .ev_unknown_opcode(ev[12]), .ev_bad_state(ev[13]), .ev_misalign(ev[14]), .ev_zero_div(ev[15]),
      .ev_return_load(ev[16]), .exception_return_value(acc_addr), .fault_access_addr(acc_addr),
      .in_handler(in_handler), .exec_class(exec_class), .exec_pri(exec_pri),
      .entering_bus_handler(entering_bus_handler), .nmi_req(nmi_req), .debug_halt(debug_halt),
      .fault_take(fault_take), .fault_take_class(fault_take_class), .lockup(lockup));

   // 20 MHz core clock
   initial begin
      forever #25 clk_sys = ~clk_sys;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("MISMATCH at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys); reg_wr <= 1; reg_addr <= a; reg_wdata <= d;
      @(posedge clk_sys); reg_wr <= 0;
   endtask
   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [7:0] a);
      @(posedge clk_sys); reg_rd <= 1; reg_addr <= a;
      @(posedge clk_sys); reg_rd <= 0;
      #1 rd_v = reg_rdata;
   endtask
   task automatic ctx(input logic h, input logic [2:0] c, input logic [2:0] p);
      @(posedge clk_sys); in_handler <= h; exec_class <= c; exec_pri <= p;
   endtask
   // returns just after the edge that samples the report
   task automatic fire_ev(input int i, input logic [31:0] a);
      @(posedge clk_sys); fire <= 1; sel <= i[4:0]; src_addr <= a;
      @(posedge clk_sys); fire <= 0;
      @(posedge clk_sys); #1;
   endtask
   task automatic state_is(input logic l, input logic t, input logic [2:0] c);
      chk({27'h0, lockup, fault_take, fault_take_class}, {27'h0, l, t, c});
   endtask
   task automatic kick(input logic n, input logic d);
      @(posedge clk_sys); nmi_req <= n; debug_halt <= d;
      @(posedge clk_sys); nmi_req <= 0; debug_halt <= 0;
      #1;
   endtask
   task automatic close_out;
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask

   // main sequence
   initial begin
      repeat (5) @(posedge clk_sys);
      rst <= 0;
      rd(8'h1C); chk(rd_v, 32'h0);
      wr(8'h1C, 32'h7); wr(8'h18, 32'h0002_0000);
      rd(8'h1C); chk(rd_v, 32'h7);
      rd(8'h18); chk(rd_v, 32'h0002_0000);
      rd(8'h40); chk(rd_v, 32'h0);
      for (int i = 0; i < 17; i++) begin
         fire_ev(i, (i == 16) ? 32'hFFFFFFF5 : 32'h2000_0100 + i * 4);
         state_is(0, 1, CLS[i][2:0]);
         expf[RIX[i]] |= 32'h1 << BITN[i];
         rd(8'(RIX[i] * 4)); chk(rd_v & expf[RIX[i]], expf[RIX[i]]);
         if (i == 3) begin rd(8'h10); chk(rd_v, 32'h2000_010C); end
         if (i == 9) begin rd(8'h14); chk(rd_v, 32'h2000_0124); end
      end
      foreach (expf[k]) begin
         fire_ev(16, 32'hFFFFFFF1 | (k << 2)); state_is(0, k == 1, (k == 1) ? 3'h4 : 3'h0);
      end
      fire_ev(16, 32'h7FFFFFF9); state_is(0, 1, 3'h4);
      wr(8'h0C, 32'hFFFFFFFF); rd(8'h0C); chk(rd_v, 32'h0);
      wr(8'h1C, 32'h0); fire_ev(15, 0); state_is(0, 1, 3'h1);
      rd(8'h00); chk(rd_v & 32'h4000_0000, 32'h4000_0000);
      rd(8'h0C); chk(rd_v & 32'h200, 32'h200);
      @(posedge clk_sys); entering_bus_handler <= 1;
      fire_ev(6, 32'h2000_0400); state_is(0, 1, 3'h3);
      @(posedge clk_sys); entering_bus_handler <= 0;
      wr(8'h1C, 32'h7);
      ctx(1, 6, 2); fire_ev(14, 0); state_is(0, 1, 3'h1);
      ctx(1, 6, 3); fire_ev(14, 0); state_is(0, 1, 3'h4);
      ctx(1, 4, 3); fire_ev(15, 0); state_is(0, 1, 3'h1);
      ctx(1, 2, 0); fire_ev(0, 0); state_is(0, 1, 3'h1);
      ctx(1, 1, 0); fire_ev(0, 0); state_is(1, 0, 3'h0);
      fire_ev(11, 0); state_is(1, 0, 3'h0);
      rd(8'h20); chk(rd_v & 32'h3, 32'h1);
      kick(1, 0); state_is(0, 0, 3'h0);
      ctx(1, 5, 0); fire_ev(0, 0); state_is(1, 0, 3'h0);
      kick(1, 0); state_is(1, 0, 3'h0);
      kick(0, 1); state_is(0, 0, 3'h0);
      ctx(1, 1, 0); fire_ev(0, 0); state_is(1, 0, 3'h0);
      @(posedge clk_sys); rst <= 1;
      repeat (2) @(posedge clk_sys);
      rst <= 0;
      rd(8'h08); chk(rd_v, 32'h0);
      state_is(0, 0, 3'h0);
      rd(8'h1C); chk(rd_v, 32'h0);
      close_out;
   end

   // hang guard, far beyond the roughly 190 cycles the run needs
   initial begin
      #(50 * 5000);
      bad_count++;
      close_out;
   end
endmodule // tb_top
